/* File: include/fsp_pkg.sv */
// Constants, register map and carrier types of the flash status and protect block.
package fsp_pkg;

	// ------------------------------------------------------------------
	// Bus geometry
	// ------------------------------------------------------------------
	localparam int unsigned ADDR_W = 32;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned NBLK   = 4;
	localparam int unsigned BLK_W  = 2;
	localparam int unsigned NUM_EV = 4;

	// ------------------------------------------------------------------
	// Register byte addresses
	// ------------------------------------------------------------------
	localparam logic [ADDR_W-1:0] ADDR_ROM_PROT   = 32'hffffe518;
	localparam logic [ADDR_W-1:0] ADDR_FLASH_STAT = 32'hffffe520;
	localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT   = 32'hffffe528;
	localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK   = 32'hffffe52c;

	// ------------------------------------------------------------------
	// Field positions and reset values
	// ------------------------------------------------------------------
	localparam int unsigned READY_BIT   = 0;
	localparam int unsigned ROMKIND_BIT = 2;
	localparam int unsigned GUARD_LSB   = 4;
	localparam int unsigned PROT_EN_BIT = 0;
	localparam logic        PROT_EN_RST = 1'b1;
	localparam logic [NBLK-1:0]   GUARD_RST = 4'h0;
	localparam logic [NBLK-1:0]   GUARD_ALL = 4'hf;
	localparam logic [NUM_EV-1:0] IRQ_RST   = 4'h0;

	// Event bit positions in the interrupt status and mask registers.
	localparam int unsigned EV_DONE    = 0;
	localparam int unsigned EV_FAIL    = 1;
	localparam int unsigned EV_REFUSE  = 2;
	localparam int unsigned EV_BLOCKED = 3;

	// ------------------------------------------------------------------
	// Types
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {
		FSP_READY  = 2'b00,
		FSP_BUSY   = 2'b01,
		FSP_FAILED = 2'b11
	} fsp_mon_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic              wr;
		logic              rd;
		logic              from_rom;
	} fsp_bus_req_t;

	typedef struct packed {
		fsp_mon_t          mon;
		logic              kind_s1;
		logic              kind_s2;
		logic              kind_cap;
		logic              rom_kind;
		logic              prot_en;
		logic [NBLK-1:0]   guard;
		logic [NUM_EV-1:0] irq_stat;
		logic [NUM_EV-1:0] irq_mask;
		logic [DATA_W-1:0] rdata;
	} fsp_state_t;

endpackage

/* File: testbench/fsp_flash_model.sv */
// Behavioural model of the flash sequencer that feeds the status block.
`timescale 1ns/1ps

module fsp_flash_model #(
	parameter int OP_LEN = 8
) (
	input  wire logic       mclk_i,
	input  wire logic       rstn_i,
	input  wire logic       start_i,
	input  wire logic       fail_i,
	input  wire logic [3:0] guard_i,
	output logic            busy_o,
	output logic            fail_o,
	output logic [3:0]      guard_o
);
	int cnt;

	// An operation runs a fixed count; a system reset aborts it at once.
	always @(posedge mclk_i)
	begin
		if (!rstn_i)
			cnt <= 0;
		else if (start_i)
			cnt <= OP_LEN;
		else if (cnt != 0)
			cnt <= cnt - 1;
		guard_o <= guard_i; // One protect bit per block.
	end

	// A failing run flags only in its last busy cycle, the latest case.
	assign busy_o = (cnt != 0);
	assign fail_o = fail_i && (cnt == 1);
endmodule // fsp_flash_model

/* File: testbench/fsp_regs_test.sv */
// Self-checking bench of the flash status and protect registers.
`timescale 1ns/1ps

module fsp_regs_test
	import fsp_pkg::*;
;
	logic              mclk_i = 1'b0;
	logic              rstn_i = 1'b0;
	logic              porn_i = 1'b0;
	logic              kind_pin = 1'b0;
	logic              start = 1'b0;
	logic              fail_mode = 1'b0;
	logic              reset_cmd = 1'b0;
	logic              ce = 1'b1;
	logic              pe_req = 1'b0;
	logic [BLK_W-1:0]  pe_block = '0;
	logic [NBLK-1:0]   guard_set = '0;
	logic [NBLK-1:0]   guard;
	logic              busy, fail, grant, active, ready, irq;
	fsp_bus_req_t      bus = '0;
	logic [DATA_W-1:0] rdata;
	logic [31:0]       seed = 32'h9bb5;
	logic [31:0]       exp_q[$];
	logic              rd_pend = 1'b0;
	int                num_errors = 0;
	int                samples_checked = 0;

	always #10 mclk_i = ~mclk_i;

	fsp_regs uut (
		.mclk_i               (mclk_i),
		.rstn_i               (rstn_i),
		.porn_i               (porn_i),
		.ce_i                 (ce),
		.bus_i                (bus),
		.rdata_o              (rdata),
		.rom_kind_pin_i       (kind_pin),
		.auto_op_busy_i       (busy),
		.auto_op_fail_i       (fail),
		.flash_reset_cmd_i    (reset_cmd),
		.block_guard_i        (guard),
		.pe_req_i             (pe_req),
		.pe_block_i           (pe_block),
		.pe_grant_o           (grant),
		.rom_protect_active_o (active),
		.auto_op_ready_flag_o (ready),
		.irq_o                (irq)
	);

	fsp_flash_model model (
		.mclk_i  (mclk_i),
		.rstn_i  (rstn_i),
		.start_i (start),
		.fail_i  (fail_mode),
		.guard_i (guard_set),
		.busy_o  (busy),
		.fail_o  (fail),
		.guard_o (guard)
	);

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	function automatic logic [31:0] xrand();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	task automatic print_verdict();
		$display("Checks: %0d, mismatches: %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic cmp_data(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			num_errors++;
			$display("unexpected at %0t: got %h, want %h", $time, got, exp);
		end
	endtask

	// Flags are looked at mid-cycle so that edge updates have landed.
	task automatic cmp_flag(const ref logic got_sig, input logic exp);
		@(negedge mclk_i);
		cmp_data({31'h0, got_sig}, {31'h0, exp});
	endtask

	task automatic wr_reg(input logic [31:0] a, input logic [31:0] d,
		input logic rom);
		@(posedge mclk_i);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0, from_rom: rom};
		@(posedge mclk_i);
		bus.wr <= 1'b0;
	endtask

	// The expectation is queued with the request and checked on reply.
	task automatic rd_reg(input logic [31:0] a, input logic [31:0] e,
		input logic rom);
		@(posedge mclk_i);
		bus <= '{addr: a, wdata: '0, wr: 1'b0, rd: 1'b1, from_rom: rom};
		exp_q.push_back(e);
		@(posedge mclk_i);
		bus.rd <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe, else zero.
	always @(negedge mclk_i)
	begin
		if (rd_pend && exp_q.size() > 0)
			cmp_data(rdata, exp_q.pop_front());
		else if (rstn_i && porn_i)
			cmp_data(rdata, 32'h0);
		rd_pend = bus.rd;
	end

	task automatic do_reset(input logic por);
		rstn_i <= 1'b0;
		porn_i <= !por;
		repeat (6) @(posedge mclk_i);
		rstn_i <= 1'b1;
		porn_i <= 1'b1;
		repeat (4) @(posedge mclk_i);
	endtask

	task automatic run_op();
		@(posedge mclk_i);
		start <= 1'b1;
		@(posedge mclk_i);
		start <= 1'b0;
	endtask

	task automatic pulse_cmd();
		@(posedge mclk_i);
		reset_cmd <= 1'b1;
		@(posedge mclk_i);
		reset_cmd <= 1'b0;
	endtask

	// A stuck sequencer must not hang the run. The flag is looked at
	// mid-cycle, and the task returns just after a rising edge.
	task automatic wait_ready();
		int n;
		n = 0;
		@(negedge mclk_i);
		while (ready !== 1'b1 && n < 100)
		begin
			@(negedge mclk_i);
			n++;
		end
		if (ready === 1'b1)
		begin
			@(posedge mclk_i);
		end
		else
		begin
			cmp_data({31'h0, ready}, 32'h1);
			print_verdict();
		end
	endtask

	// ------------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------------
	initial
	begin
		logic [31:0]     d;
		logic [NBLK-1:0] g;
		do_reset(1'b1);
		rd_reg(ADDR_FLASH_STAT, 32'h1, 1'b0);
		rd_reg(ADDR_ROM_PROT, 32'h1, 1'b0);
		rd_reg(ADDR_IRQ_MASK, 32'h0, 1'b0);
		// A write made while the clock enable is low must not land.
		ce <= 1'b0;
		wr_reg(ADDR_IRQ_MASK, 32'hf, 1'b0);
		ce <= 1'b1;
		rd_reg(ADDR_IRQ_MASK, 32'h0, 1'b0);
		wr_reg(32'hffffe524, xrand(), 1'b0);
		rd_reg(32'hffffe524, 32'h0, 1'b0);
		wr_reg(ADDR_FLASH_STAT, xrand(), 1'b0);
		rd_reg(ADDR_FLASH_STAT, 32'h1, 1'b0);
		wr_reg(ADDR_ROM_PROT, xrand() & 32'hfffffffe, 1'b1);
		rd_reg(ADDR_ROM_PROT, 32'h0, 1'b1);
		// Busy, a reset command that forces ready, then completion.
		wr_reg(ADDR_IRQ_STAT, 32'hf, 1'b0);
		run_op();
		repeat (2) @(posedge mclk_i);
		rd_reg(ADDR_FLASH_STAT, 32'h0, 1'b0);
		pulse_cmd();
		cmp_flag(ready, 1'b1);
		wait_ready();
		rd_reg(ADDR_FLASH_STAT, 32'h1, 1'b0);
		rd_reg(ADDR_IRQ_STAT, 32'h1, 1'b0);
		fail_mode <= 1'b1;
		run_op();
		repeat (12) @(posedge mclk_i);
		rd_reg(ADDR_FLASH_STAT, 32'h0, 1'b0);
		fail_mode <= 1'b0;
		pulse_cmd();
		cmp_flag(ready, 1'b0);
		@(posedge mclk_i);
		do_reset(1'b0);
		rd_reg(ADDR_FLASH_STAT, 32'h1, 1'b0);
		rd_reg(ADDR_ROM_PROT, 32'h0, 1'b0);
		do_reset(1'b1);
		rd_reg(ADDR_ROM_PROT, 32'h1, 1'b0);
		// Random guard patterns, alternating the target block's bit.
		for (int b = 0; b < NBLK; b++)
		begin
			d = xrand();
			g = d[NBLK-1:0];
			g[b] = b[0];
			guard_set <= g;
			pe_block <= b[BLK_W-1:0];
			pe_req <= 1'b1;
			repeat (3) @(posedge mclk_i);
			cmp_flag(grant, !g[b]);
			rd_reg(ADDR_FLASH_STAT, {24'h0, g, 4'h1}, 1'b0);
		end
		guard_set <= '0;
		pe_block <= '0;
		run_op();
		repeat (3) @(posedge mclk_i);
		cmp_flag(grant, 1'b0);
		wait_ready();
		pe_req <= 1'b0;
		guard_set <= GUARD_ALL;
		wr_reg(ADDR_IRQ_STAT, 32'hf, 1'b0);
		repeat (2) @(posedge mclk_i);
		cmp_flag(active, 1'b1);
		rd_reg(ADDR_ROM_PROT, 32'h0, 1'b0);
		wr_reg(ADDR_ROM_PROT, 32'h0, 1'b0);
		rd_reg(ADDR_ROM_PROT, 32'h1, 1'b1);
		rd_reg(ADDR_IRQ_STAT, 32'h8, 1'b0);
		wr_reg(ADDR_IRQ_MASK, 32'h8, 1'b0);
		cmp_flag(irq, 1'b1);
		wr_reg(ADDR_IRQ_STAT, 32'h8, 1'b0);
		cmp_flag(irq, 1'b0);
		wr_reg(ADDR_ROM_PROT, 32'h0, 1'b1);
		cmp_flag(active, 1'b0);
		// Mask part: kind strap high, guard and ready forced.
		@(posedge mclk_i);
		kind_pin <= 1'b1;
		guard_set <= '0;
		do_reset(1'b1);
		rd_reg(ADDR_FLASH_STAT, 32'hf5, 1'b0);
		repeat (2) @(posedge mclk_i);
		print_verdict();
	end
endmodule // fsp_regs_test

/* File: verilog/fsp_block_gate.sv */
// Per-block program and erase gate of the flash status and protect block.
`timescale 1ns/1ps

module fsp_block_gate
	import fsp_pkg::*;
(
	input  wire logic [NBLK-1:0]  guard_i,
	input  wire logic             ready_i,
	input  wire logic             req_i,
	input  wire logic [BLK_W-1:0] block_i,
	output logic                  grant_o,
	output logic                  refuse_o
);

	logic [NBLK-1:0] hit;

	// ------------------------------------------------------------------
	// Block decode
	// ------------------------------------------------------------------
	// One compare per block; a guarded block never passes a request.
	for (genvar i = 0; i < NBLK; i++)
	begin : g_blk
		assign hit[i] = guard_i[i] && (block_i == BLK_W'(i));
	end

	// A request is granted only to an unguarded block of a ready flash.
	assign grant_o  = req_i && ready_i && !(|hit);
	assign refuse_o = req_i && !grant_o;

endmodule // fsp_block_gate

/* File: verilog/fsp_regs.sv */
// Flash status, block guard and ROM protect registers with interrupt logic.
//
// Overview of operation
// - Ready flag reads 0 during an automatic operation, 1 once finished.
// - A failed operation keeps the ready flag at 0 until hardware reset.
// - A command while busy may jam; system reset or reset command recovers.
// - Bit 2 reads 0 for rewritable flash, 1 for mask ROM, set at reset.
// - Bits 7 to 4 hold one guard bit per 128 KB block.
// - Program or erase aimed at a guarded block is refused.
// - Flash status register is read-only; unused bits read 0.
// - Protect enable bit 0 is read/write, 1 after power-on, others read 0.
// - ROM data protection acts only when enabled and all blocks guarded.
// - Under protection, only ROM-fetched code reaches the protect register.
// - Flash variant resets protection only at power-on; mask at any reset.
`timescale 1ns/1ps

module fsp_regs
	import fsp_pkg::*;
(
	input  wire logic              mclk_i,
	input  wire logic              rstn_i,
	input  wire logic              porn_i,
	input  wire logic              ce_i,
	input  wire fsp_bus_req_t      bus_i,
	output logic [DATA_W-1:0]      rdata_o,
	input  wire logic              rom_kind_pin_i,
	input  wire logic              auto_op_busy_i,
	input  wire logic              auto_op_fail_i,
	input  wire logic              flash_reset_cmd_i,
	input  wire logic [NBLK-1:0]   block_guard_i,
	input  wire logic              pe_req_i,
	input  wire logic [BLK_W-1:0]  pe_block_i,
	output logic                   pe_grant_o,
	output logic                   rom_protect_active_o,
	output logic                   auto_op_ready_flag_o,
	output logic                   irq_o
);

	// ------------------------------------------------------------------
	// State and helper signals
	// ------------------------------------------------------------------
	fsp_state_t        st;
	fsp_state_t        next_st;
	logic              any_rst;
	logic              ready;
	logic              prot_active;
	logic              hit_rp;
	logic              hit_fs;
	logic              hit_is;
	logic              hit_im;
	logic              blocked;
	logic              refuse;
	logic [NUM_EV-1:0] ev;
	logic [NUM_EV-1:0] clr;
	logic [DATA_W-1:0] fs_word;

	// Both resets are synchronous and active low.
	assign any_rst = !rstn_i || !porn_i;

	// The flag is low while busy and stays low after a failure.
	assign ready = (st.mon == FSP_READY);

	// Protection needs the enable bit and every block guarded.
	assign prot_active = st.prot_en && (&st.guard);

	// ------------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------------
	// Decodes compare the whole address, so aliases read as unmapped.
	assign hit_rp = (bus_i.addr == ADDR_ROM_PROT);
	assign hit_fs = (bus_i.addr == ADDR_FLASH_STAT);
	assign hit_is = (bus_i.addr == ADDR_IRQ_STAT);
	assign hit_im = (bus_i.addr == ADDR_IRQ_MASK);

	// Code fetched outside ROM may neither read nor write the protect
	// register while protection is active.
	assign blocked = prot_active && !bus_i.from_rom
		&& (bus_i.wr || bus_i.rd) && hit_rp;

	// ------------------------------------------------------------------
	// Program and erase gate
	// ------------------------------------------------------------------
	// Requests are also refused while not ready, since a command given
	// to a busy flash is the usual way it jams.
	fsp_block_gate u_gate
	(
		.guard_i  (st.guard),
		.ready_i  (ready),
		.req_i    (pe_req_i),
		.block_i  (pe_block_i),
		.grant_o  (pe_grant_o),
		.refuse_o (refuse)
	);

	// ------------------------------------------------------------------
	// Events
	// ------------------------------------------------------------------
	// Each event sets a sticky status bit; done and fail last one cycle, refuse and blocked last while their cause holds.
	always_comb
	begin
		ev = '0;
		ev[EV_DONE] = (st.mon == FSP_BUSY) && !auto_op_busy_i
			&& !auto_op_fail_i;
		ev[EV_FAIL] = (st.mon == FSP_BUSY) && auto_op_fail_i;
		ev[EV_REFUSE] = refuse;
		ev[EV_BLOCKED] = blocked;
	end

	// Write-one-to-clear mask for the status register.
	assign clr = (bus_i.wr && hit_is) ? bus_i.wdata[NUM_EV-1:0] : '0;

	// ------------------------------------------------------------------
	// Flash status word
	// ------------------------------------------------------------------
	// Only the monitor, kind and guard bits exist; the rest read 0.
	always_comb
	begin
		fs_word = '0;
		fs_word[READY_BIT] = ready;
		fs_word[ROMKIND_BIT] = st.rom_kind;
		fs_word[GUARD_LSB +: NBLK] = st.guard;
	end

	// ------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------
	always_comb
	begin
		next_st = st;

		// Strap synchroniser; only the second stage is ever looked at.
		next_st.kind_s1 = rom_kind_pin_i;
		next_st.kind_s2 = st.kind_s1;

		// The kind is taken once, the first cycle after reset release.
		if (!st.kind_cap)
		begin
			next_st.rom_kind = st.kind_s2;
			next_st.kind_cap = 1'b1;
		end

		// Auto-operation monitor.
		unique case (st.mon)
			FSP_READY:
			begin
				if (auto_op_busy_i)
				begin
					next_st.mon = FSP_BUSY;
				end
			end
			FSP_BUSY:
			begin
				if (auto_op_fail_i)
				begin
					next_st.mon = FSP_FAILED;
				end
				else if (flash_reset_cmd_i)
				begin
					next_st.mon = FSP_READY;
				end
				else if (!auto_op_busy_i)
				begin
					next_st.mon = FSP_READY;
				end
			end
			FSP_FAILED:
			begin
				next_st.mon = FSP_FAILED;
			end
			default:
			begin
				next_st.mon = FSP_READY;
			end
		endcase

		// A mask ROM never runs automatic operations and is fully
		// guarded except while in reset, which loads GUARD_RST.
		if (st.rom_kind)
		begin
			next_st.mon = FSP_READY;
			next_st.guard = GUARD_ALL;
		end
		else
		begin
			next_st.guard = block_guard_i;
		end

		// Protect enable write, dropped when the access is blocked.
		if (bus_i.wr && hit_rp && !blocked)
		begin
			next_st.prot_en = bus_i.wdata[PROT_EN_BIT];
		end

		// A new event wins over a clear in the same cycle.
		next_st.irq_stat = (st.irq_stat & ~clr) | ev;
		if (bus_i.wr && hit_im)
		begin
			next_st.irq_mask = bus_i.wdata[NUM_EV-1:0];
		end

		// Read data stand for exactly one cycle after the strobe. The
		// flash status register has no write path at all.
		next_st.rdata = '0;
		if (bus_i.rd)
		begin
			if (hit_fs)
			begin
				next_st.rdata = fs_word;
			end
			else if (hit_rp && !blocked)
			begin
				next_st.rdata[PROT_EN_BIT] = st.prot_en;
			end
			else if (hit_is)
			begin
				next_st.rdata[NUM_EV-1:0] = st.irq_stat;
			end
			else if (hit_im)
			begin
				next_st.rdata[NUM_EV-1:0] = st.irq_mask;
			end
		end

		// Any reset clears the monitor and events. The synchroniser
		// keeps sampling the strap through reset, so the kind taken at
		// release is the settled strap; a reset shorter than two
		// cycles may capture a stale value. The kind flop survives a
		// system reset so that a flash part keeps its protect enable;
		// it is then captured afresh.
		if (any_rst)
		begin
			next_st.mon = FSP_READY;
			next_st.kind_cap = 1'b0;
			next_st.guard = GUARD_RST;
			next_st.irq_stat = IRQ_RST;
			next_st.irq_mask = IRQ_RST;
			next_st.rdata = '0;
			if (!porn_i || st.rom_kind)
			begin
				next_st.prot_en = PROT_EN_RST;
			end
			if (!porn_i)
			begin
				next_st.rom_kind = 1'b0;
			end
		end
	end

	// ------------------------------------------------------------------
	// State register
	// ------------------------------------------------------------------
	// Reset overrides the clock enable so a frozen block still resets.
	always_ff @(posedge mclk_i)
	begin
		if (any_rst || ce_i)
		begin
			st <= next_st;
		end
	end

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------
	assign rdata_o = st.rdata;
	assign rom_protect_active_o = prot_active;
	assign auto_op_ready_flag_o = ready;
	assign irq_o = |(st.irq_stat & st.irq_mask);

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge mclk_i);
	endclocking

	default disable iff (any_rst);

	AST_READY_READ: assert property (
		(ce_i && bus_i.rd && hit_fs)
		|=> rdata_o[READY_BIT] == ($past(st.mon) == FSP_READY))
		else $error("Ready flag read does not match monitor state.");

	AST_BUSY_ENTRY: assert property (
		(ce_i && ready && auto_op_busy_i && !st.rom_kind)
		|=> !auto_op_ready_flag_o)
		else $error("Ready flag stayed high after busy began.");

	AST_FAIL_STICKS: assert property (
		(ce_i && st.mon == FSP_BUSY && auto_op_fail_i && !st.rom_kind)
		|=> (!auto_op_ready_flag_o) [*2])
		else $error("Ready flag rose after a failed operation.");

	AST_KIND_READ: assert property (
		(ce_i && bus_i.rd && hit_fs)
		|=> rdata_o[ROMKIND_BIT] == $past(st.rom_kind))
		else $error("Kind bit read does not match captured kind.");

	AST_GUARD_READ: assert property (
		(ce_i && bus_i.rd && hit_fs)
		|=> rdata_o[GUARD_LSB +: NBLK] == $past(st.guard))
		else $error("Guard field read does not match guard state.");

	AST_REFUSE: assert property (
		(pe_req_i && st.guard[pe_block_i]) |-> !pe_grant_o)
		else $error("Request to a guarded block was granted.");

	AST_UNUSED_ZERO: assert property (
		(ce_i && bus_i.rd && hit_fs)
		|=> (rdata_o[DATA_W-1:GUARD_LSB+NBLK] == '0)
			&& !rdata_o[1] && !rdata_o[3])
		else $error("Unused flash status bit read as one.");

	AST_PROT_READ: assert property (
		(ce_i && bus_i.rd && hit_rp && !blocked)
		|=> rdata_o == {{(DATA_W-1){1'b0}}, $past(st.prot_en)})
		else $error("Protect register read is wrong.");

	AST_ACTIVE: assert property (
		rom_protect_active_o |-> (st.prot_en && st.guard == GUARD_ALL))
		else $error("Protection active without full guard and enable.");

	AST_BLOCKED_WR: assert property (
		(ce_i && bus_i.wr && hit_rp && prot_active && !bus_i.from_rom)
		|=> $stable(st.prot_en) && st.irq_stat[EV_BLOCKED])
		else $error("Blocked write reached the protect enable.");

	AST_POR_KEEP: assert property (
		@(posedge mclk_i) disable iff (!porn_i)
		(!rstn_i && !st.rom_kind) |=> $stable(st.prot_en))
		else $error("System reset changed flash protect enable.");

	AST_RO_WRITE: assert property (
		(ce_i && bus_i.wr && hit_fs)
		|=> $stable(st.prot_en) && $stable(st.irq_mask))
		else $error("Write to status register changed state.");

	COV_DONE: cover property (
		(st.mon == FSP_BUSY) ##1 (st.mon == FSP_READY));
	COV_FAIL: cover property (st.mon == FSP_FAILED);
	COV_REFUSE: cover property (pe_req_i && !pe_grant_o);
	COV_BLOCKED: cover property (blocked && bus_i.wr);

endmodule // fsp_regs
